// file: include/hbs_pkg.sv
// Shared constants, types and helpers for the host bus strap glue pair.
// Assumes both ends run on the one pclk and share the presetn reset.
package hbs_pkg;

	// ******************************************
	// Register offsets of the host end (APB)
	// ******************************************
	localparam logic [11:0] HBS_CMD_OFS = 12'h000;
	localparam logic [11:0] HBS_ADDR_OFS = 12'h004;
	localparam logic [11:0] HBS_WDATA_OFS = 12'h008;
	localparam logic [11:0] HBS_STRB_OFS = 12'h00c;
	localparam logic [11:0] HBS_RDATA_OFS = 12'h010;
	localparam logic [11:0] HBS_STAT_OFS = 12'h014;

	// ******************************************
	// Field positions
	// ******************************************
	localparam int HBS_CMD_START_BIT = 0;
	localparam int HBS_CMD_READ_BIT = 1;
	localparam int HBS_STAT_BUSY_BIT = 0;
	localparam int HBS_STAT_DONE_BIT = 1;
	localparam int HBS_STRB_EN0_BIT = 0;
	localparam int HBS_STRB_EN1_BIT = 1;

	// ******************************************
	// Values after reset and counts
	// ******************************************
	localparam logic [15:0] HBS_ADDR_RST = 16'h0000;
	localparam logic [15:0] HBS_WDATA_RST = 16'h0000;
	localparam logic [15:0] HBS_RDATA_RST = 16'h0000;
	localparam logic [1:0] HBS_STRB_RST = 2'h3;
	localparam logic HBS_PANEL_RST = 1'h0;
	// Edges after release before the synchronised straps are trusted
	localparam logic [1:0] HBS_STRAP_SETTLE = 2'h2;
	localparam int HBS_MEM_AW = 5;
	localparam int HBS_MEM_WORDS = 32;

	// Host interface modes picked by the straps
	typedef enum logic [2:0] {
		HBS_MODE_STRB_A,
		HBS_MODE_STRB_B,
		HBS_MODE_DS_A,
		HBS_MODE_DS_B,
		HBS_MODE_GEN1,
		HBS_MODE_GEN2,
		HBS_MODE_RSVD
	} hbs_mode_t;

	// Strap code plus bus start pin to mode
	function automatic hbs_mode_t hbs_decode_mode(input logic [2:0] code, input logic start_n);
		case (code)
			3'h0: hbs_decode_mode = HBS_MODE_STRB_A;
			3'h1: hbs_decode_mode = HBS_MODE_STRB_B;
			3'h3: hbs_decode_mode = HBS_MODE_DS_A;
			3'h5: hbs_decode_mode = HBS_MODE_DS_B;
			3'h7: hbs_decode_mode = start_n ? HBS_MODE_GEN2 : HBS_MODE_GEN1;
			default: hbs_decode_mode = HBS_MODE_RSVD;
		endcase
	endfunction

	// Swap the two byte lanes of a word
	function automatic logic [15:0] hbs_lane_swap(input logic [15:0] d);
		hbs_lane_swap = {d[7:0], d[15:8]};
	endfunction

	// Processor lines numbered MSB-first onto device bits LSB-first
	function automatic logic [15:0] hbs_cross(input logic [0:15] lines);
		logic [15:0] r;
		r = 16'h0000;
		for (int k = 0; k < 16; k++) begin
			r[15 - k] = lines[k];
		end
		hbs_cross = r;
	endfunction

endpackage

// file: include/hbs_link_if.sv
// Board wiring between the processor glue and the display controller.
// Assumes the bench resolves nothing further: data_bus is worked out here.
`timescale 1ns/10ps
`default_nettype none
interface hbs_link_if;
	logic cs_n; // Chip select, low active
	logic [15:0] addr; // Device address bits
	logic [15:0] host_data; // Write data from the glue
	logic host_data_oe_n; // Glue drives data when low
	logic [15:0] dev_data; // Read data from the device
	logic dev_data_oe_n; // Device drives data when low
	logic [15:0] data_bus; // Resolved data wires
	logic low_byte_write_n;
	logic high_byte_write_n;
	logic low_byte_read_n;
	logic high_byte_read_n;
	logic bus_start_strobe_n;
	logic wait_n; // Low holds the cycle, high lets it end

	// Device wins a clash; undriven wires float high on the pull-up
	assign data_bus = !dev_data_oe_n ? dev_data : (!host_data_oe_n ? host_data : 16'hffff);

	modport host (
		output cs_n, addr, host_data, host_data_oe_n,
		output low_byte_write_n, high_byte_write_n,
		output low_byte_read_n, high_byte_read_n, bus_start_strobe_n,
		input data_bus, wait_n
	);
	modport dev (
		input cs_n, addr, data_bus,
		input low_byte_write_n, high_byte_write_n,
		input low_byte_read_n, high_byte_read_n, bus_start_strobe_n,
		output dev_data, dev_data_oe_n, wait_n
	);
endinterface
`default_nettype wire

// file: verilog/hbs_host.sv
// Processor end: APB-controlled bus cycle engine plus the acknowledge glue.
// Assumes the device end sits on the same pclk behind hbs_link_if.
`timescale 1ns/10ps
`default_nettype none
module hbs_host import hbs_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic transfer_ack_n,
	output logic transfer_ack_oe_n,
	hbs_link_if.host link
);

	typedef enum logic {H_IDLE, H_ACCESS} hbs_hstate_t;

	// ******************************************
	// State
	// ******************************************
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic [15:0] addr_r, addr_nxt; // Value of processor lines A16..A31
	logic [15:0] wdata_r, wdata_nxt; // Value of processor lines D0..D15
	logic [15:0] rdata_r, rdata_nxt;
	logic [1:0] strb_r, strb_nxt; // Processor byte strobes 0 and 1
	logic pend_r, pend_nxt; // Cycle ordered, not yet started
	logic rd_r, rd_nxt; // Ordered cycle is a read
	logic done_r, done_nxt; // Sticky completion
	hbs_hstate_t st_r, st_nxt;
	logic cs_n_r, cs_n_nxt;
	logic [15:0] bus_addr_r, bus_addr_nxt;
	logic [15:0] bus_wd_r, bus_wd_nxt;
	logic wd_oe_n_r, wd_oe_n_nxt;
	logic lo_we_n_r, lo_we_n_nxt;
	logic hi_we_n_r, hi_we_n_nxt;
	logic rd_n_r, rd_n_nxt;
	logic ack_n_r, ack_n_nxt;
	logic ack_oe_n_r, ack_oe_n_nxt;
	logic bus_start_r;
	logic apb_take; // Edge where the transfer completes
	logic apb_first; // First access cycle
	logic ack_seen;

	// ******************************************
	// Next state
	// ******************************************
	// APB slave answers in the second access cycle; writes land then
	always_comb begin
		apb_first = psel & penable & ~pready_r;
		apb_take = psel & penable & pready_r;
		pready_nxt = apb_first;
		pslverr_nxt = 1'b0;
		prdata_nxt = prdata_r;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		strb_nxt = strb_r;
		pend_nxt = pend_r;
		rd_nxt = rd_r;
		done_nxt = done_r;
		rdata_nxt = rdata_r;
		st_nxt = st_r;
		cs_n_nxt = cs_n_r;
		bus_addr_nxt = bus_addr_r;
		bus_wd_nxt = bus_wd_r;
		wd_oe_n_nxt = wd_oe_n_r;
		lo_we_n_nxt = lo_we_n_r;
		hi_we_n_nxt = hi_we_n_r;
		rd_n_nxt = rd_n_r;
		// Read mux and unmapped check in the first access cycle
		if (apb_first) begin
			case (paddr)
				HBS_CMD_OFS: prdata_nxt = {30'h0, rd_r, pend_r};
				HBS_ADDR_OFS: prdata_nxt = {16'h0, addr_r};
				HBS_WDATA_OFS: prdata_nxt = {16'h0, wdata_r};
				HBS_STRB_OFS: prdata_nxt = {30'h0, strb_r};
				HBS_RDATA_OFS: prdata_nxt = {16'h0, rdata_r};
				HBS_STAT_OFS: prdata_nxt = {30'h0, done_r, pend_r | (st_r == H_ACCESS)};
				default: begin
					prdata_nxt = 32'h0;
					pslverr_nxt = 1'b1;
				end
			endcase
		end
		// Register writes; a new order while busy is dropped
		if (apb_take && pwrite) begin
			case (paddr)
				HBS_CMD_OFS: begin
					if (pwdata[HBS_CMD_START_BIT] && !pend_r && st_r == H_IDLE) begin
						pend_nxt = 1'b1;
						rd_nxt = pwdata[HBS_CMD_READ_BIT];
					end
				end
				HBS_ADDR_OFS: addr_nxt = pwdata[15:0];
				HBS_WDATA_OFS: wdata_nxt = pwdata[15:0];
				HBS_STRB_OFS: strb_nxt = pwdata[1:0];
				HBS_STAT_OFS: begin
					if (pwdata[HBS_STAT_DONE_BIT]) begin
						done_nxt = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		ack_seen = ~ack_oe_n_r & ~ack_n_r;
		case (st_r)
			H_IDLE: begin
				if (pend_r) begin
					pend_nxt = 1'b0;
					cs_n_nxt = 1'b0;
					bus_addr_nxt = hbs_cross(addr_r);
					bus_wd_nxt = hbs_cross(wdata_r);
					if (rd_r) begin
						rd_n_nxt = 1'b0;
					end else begin
						wd_oe_n_nxt = 1'b0;
						hi_we_n_nxt = ~strb_r[HBS_STRB_EN0_BIT];
						lo_we_n_nxt = ~strb_r[HBS_STRB_EN1_BIT];
					end
					st_nxt = H_ACCESS;
				end
			end
			H_ACCESS: begin
				if (ack_seen) begin
					if (!rd_n_r) begin
						rdata_nxt = hbs_cross(link.data_bus);
					end
					cs_n_nxt = 1'b1;
					wd_oe_n_nxt = 1'b1;
					lo_we_n_nxt = 1'b1;
					hi_we_n_nxt = 1'b1;
					rd_n_nxt = 1'b1;
					// Completion wins over a clear in the same cycle
					done_nxt = 1'b1;
					st_nxt = H_IDLE;
				end
			end
			default: st_nxt = H_IDLE;
		endcase
		ack_oe_n_nxt = cs_n_r;
		ack_n_nxt = cs_n_r ? 1'b1 : ~link.wait_n;
	end

	// ******************************************
	// Registers
	// ******************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
			addr_r <= HBS_ADDR_RST;
			wdata_r <= HBS_WDATA_RST;
			rdata_r <= HBS_RDATA_RST;
			strb_r <= HBS_STRB_RST;
			pend_r <= 1'b0;
			rd_r <= 1'b0;
			done_r <= 1'b0;
			st_r <= H_IDLE;
			cs_n_r <= 1'b1;
			bus_addr_r <= 16'h0000;
			bus_wd_r <= 16'h0000;
			wd_oe_n_r <= 1'b1;
			lo_we_n_r <= 1'b1;
			hi_we_n_r <= 1'b1;
			rd_n_r <= 1'b1;
			ack_n_r <= 1'b1;
			ack_oe_n_r <= 1'b1;
			bus_start_r <= 1'b0;
		end else begin
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			rdata_r <= rdata_nxt;
			strb_r <= strb_nxt;
			pend_r <= pend_nxt;
			rd_r <= rd_nxt;
			done_r <= done_nxt;
			st_r <= st_nxt;
			cs_n_r <= cs_n_nxt;
			bus_addr_r <= bus_addr_nxt;
			bus_wd_r <= bus_wd_nxt;
			wd_oe_n_r <= wd_oe_n_nxt;
			lo_we_n_r <= lo_we_n_nxt;
			hi_we_n_r <= hi_we_n_nxt;
			rd_n_r <= rd_n_nxt;
			ack_n_r <= ack_n_nxt;
			ack_oe_n_r <= ack_oe_n_nxt;
			bus_start_r <= 1'b0;
		end
	end

	// ******************************************
	// Outputs
	// ******************************************
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign transfer_ack_n = ack_n_r;
	assign transfer_ack_oe_n = ack_oe_n_r;
	assign link.cs_n = cs_n_r;
	assign link.addr = bus_addr_r;
	assign link.host_data = bus_wd_r;
	assign link.host_data_oe_n = wd_oe_n_r;
	assign link.low_byte_write_n = lo_we_n_r;
	assign link.high_byte_write_n = hi_we_n_r;
	assign link.low_byte_read_n = rd_n_r;
	assign link.high_byte_read_n = rd_n_r;
	assign link.bus_start_strobe_n = bus_start_r;

endmodule
`default_nettype wire

// file: verilog/hbs_device.sv
// Display controller end: strap capture, mode decode, host bus slave.
// Assumes pclk doubles as the host bus clock and the glue keeps its side.
`timescale 1ns/10ps
`default_nettype none
module hbs_device import hbs_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	hbs_link_if.dev link,
	input wire logic bus_select_strap_0,
	input wire logic bus_select_strap_1,
	input wire logic bus_select_strap_2,
	input wire logic byte_order_strap,
	input wire logic panel_power_polarity_strap,
	input wire logic refresh_busy,
	input wire logic panel_power_req,
	output logic panel_power_out,
	output var hbs_mode_t host_mode,
	output logic big_endian,
	output logic config_valid
);

	typedef enum logic [1:0] {D_IDLE, D_BUSY, D_READY} hbs_dstate_t;

	// ******************************************
	// Configuration state
	// ******************************************
	logic [4:0] strap_meta_r; // First synchroniser stage
	logic [4:0] strap_sync_r, strap_sync_nxt;
	logic [1:0] settle_r, settle_nxt; // Edges since reset release
	logic cfg_valid_r, cfg_valid_nxt;
	hbs_mode_t mode_r, mode_nxt;
	logic big_r, big_nxt;
	logic pol_r, pol_nxt; // Panel power active high when set
	logic pwr_r, pwr_nxt;

	// ******************************************
	// Bus state
	// ******************************************
	hbs_dstate_t st_r, st_nxt;
	logic wait_n_r, wait_n_nxt;
	logic [15:0] rd_data_r, rd_data_nxt;
	logic rd_oe_n_r, rd_oe_n_nxt;
	logic [15:0] mem [HBS_MEM_WORDS]; // Registers and buffer stand-in
	logic mem_we_lo, mem_we_hi; // Lane write enables, device order
	logic [15:0] mem_wd;
	logic [HBS_MEM_AW-1:0] idx;
	logic wr_lo, wr_hi, rd_any, cyc;

	// ******************************************
	// Configuration next state
	// ******************************************
	// Straps are board pins, so they pass two flops before use
	always_comb begin
		strap_sync_nxt = strap_meta_r;
		settle_nxt = settle_r;
		cfg_valid_nxt = cfg_valid_r;
		mode_nxt = mode_r;
		big_nxt = big_r;
		pol_nxt = pol_r;
		if (!cfg_valid_r) begin
			if (settle_r == HBS_STRAP_SETTLE) begin
				cfg_valid_nxt = 1'b1;
				mode_nxt = hbs_decode_mode(strap_sync_r[2:0], link.bus_start_strobe_n);
				big_nxt = strap_sync_r[3];
				pol_nxt = strap_sync_r[4];
			end else begin
				settle_nxt = settle_r + 2'h1;
			end
		end
		if (cfg_valid_r) begin
			pwr_nxt = pol_r ? panel_power_req : ~panel_power_req;
		end else begin
			pwr_nxt = HBS_PANEL_RST;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_meta_r <= 5'h00;
			strap_sync_r <= 5'h00;
			settle_r <= 2'h0;
			cfg_valid_r <= 1'b0;
			mode_r <= HBS_MODE_RSVD;
			big_r <= 1'b0;
			pol_r <= 1'b0;
			pwr_r <= HBS_PANEL_RST;
		end else begin
			strap_meta_r <= {panel_power_polarity_strap, byte_order_strap,
				bus_select_strap_2, bus_select_strap_1, bus_select_strap_0};
			strap_sync_r <= strap_sync_nxt;
			settle_r <= settle_nxt;
			cfg_valid_r <= cfg_valid_nxt;
			mode_r <= mode_nxt;
			big_r <= big_nxt;
			pol_r <= pol_nxt;
			pwr_r <= pwr_nxt;
		end
	end

	// ******************************************
	// Bus next state
	// ******************************************
	// Glue strobes come from flops on this same clock, so no synchroniser
	always_comb begin
		wr_lo = ~link.low_byte_write_n;
		wr_hi = ~link.high_byte_write_n;
		rd_any = ~link.low_byte_read_n | ~link.high_byte_read_n;
		cyc = ~link.cs_n & (wr_lo | wr_hi | rd_any);
		idx = link.addr[HBS_MEM_AW:1];
		st_nxt = st_r;
		wait_n_nxt = wait_n_r;
		rd_data_nxt = rd_data_r;
		rd_oe_n_nxt = rd_oe_n_r;
		mem_we_lo = 1'b0;
		mem_we_hi = 1'b0;
		mem_wd = big_r ? hbs_lane_swap(link.data_bus) : link.data_bus;
		case (st_r)
			D_IDLE: begin
				// Only generic mode one is served; other modes never answer
				if (cyc && cfg_valid_r && mode_r == HBS_MODE_GEN1) begin
					st_nxt = D_BUSY;
				end
			end
			D_BUSY: begin
				if (!cyc) begin
					// Cycle withdrawn before completion
					st_nxt = D_IDLE;
				end else if (!refresh_busy) begin
					mem_we_lo = big_r ? wr_hi : wr_lo;
					mem_we_hi = big_r ? wr_lo : wr_hi;
					if (rd_any && !(wr_lo || wr_hi)) begin
						rd_data_nxt = big_r ? hbs_lane_swap(mem[idx]) : mem[idx];
						rd_oe_n_nxt = 1'b0;
					end
					wait_n_nxt = 1'b1;
					st_nxt = D_READY;
				end
			end
			D_READY: begin
				if (!cyc) begin
					wait_n_nxt = 1'b0;
					rd_oe_n_nxt = 1'b1;
					st_nxt = D_IDLE;
				end
			end
			default: begin
				wait_n_nxt = 1'b0;
				rd_oe_n_nxt = 1'b1;
				st_nxt = D_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= D_IDLE;
			wait_n_r <= 1'b0;
			rd_data_r <= 16'h0000;
			rd_oe_n_r <= 1'b1;
		end else begin
			st_r <= st_nxt;
			wait_n_r <= wait_n_nxt;
			rd_data_r <= rd_data_nxt;
			rd_oe_n_r <= rd_oe_n_nxt;
		end
	end

	// Storage has no reset; contents are undefined until written
	always_ff @(posedge pclk) begin
		if (mem_we_lo) begin
			mem[idx][7:0] <= mem_wd[7:0];
		end
		if (mem_we_hi) begin
			mem[idx][15:8] <= mem_wd[15:8];
		end
	end

	// ******************************************
	// Outputs
	// ******************************************
	assign link.wait_n = wait_n_r;
	assign link.dev_data = rd_data_r;
	assign link.dev_data_oe_n = rd_oe_n_r;
	assign panel_power_out = pwr_r;
	assign host_mode = mode_r;
	assign big_endian = big_r;
	assign config_valid = cfg_valid_r;

endmodule
`default_nettype wire

// file: bench/hbs_assertions.sv
// Checker on the wires between the glue end and the display end.
// Assumes one pclk domain and instantiation beside the link interface.
`timescale 1ns/10ps
`default_nettype none
module hbs_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cs_n,
	input wire logic wait_n,
	input wire logic dev_data_oe_n,
	input wire logic low_byte_write_n,
	input wire logic high_byte_write_n,
	input wire logic low_byte_read_n,
	input wire logic high_byte_read_n,
	input wire logic bus_start_strobe_n,
	input wire logic transfer_ack_n,
	input wire logic transfer_ack_oe_n
);
	// *****
	// Link properties
	// *****
	// All on pclk; reset masks the first edges where $past sees reset values
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_BS_LOW: assert property (bus_start_strobe_n == 1'b0)
		else $error("bus start strobe not held low");
	AST_RD_PAIR: assert property (low_byte_read_n == high_byte_read_n)
		else $error("read enables differ");
	AST_ACK_OE: assert property (transfer_ack_oe_n == $past(cs_n))
		else $error("acknowledge driven outside select");
	AST_ACK_INV: assert property (transfer_ack_n == ($past(cs_n) | !$past(wait_n)))
		else $error("acknowledge is not inverted wait");
	AST_WAIT_SEL: assert property ($rose(wait_n) |-> !cs_n)
		else $error("wait released with no cycle");
	AST_WAIT_IDLE: assert property ($fell(cs_n) |-> !wait_n)
		else $error("wait not holding at cycle start");
	AST_RD_DRIVE: assert property ($rose(wait_n) && !low_byte_read_n |-> !dev_data_oe_n)
		else $error("read released before data driven");
	AST_ACK_END: assert property (!transfer_ack_n |=> cs_n)
		else $error("cycle not ended by acknowledge");
	AST_ACK_BOUND: assert property ($fell(cs_n) |-> ##[2:40] !transfer_ack_n)
		else $error("cycle never acknowledged");
	AST_STRB_SEL: assert property ((!low_byte_write_n || !high_byte_write_n || !low_byte_read_n)
		|-> !cs_n)
		else $error("strobe outside select");
endmodule
`default_nettype wire

// file: bench/host_bus_strap_glue_tb_top.sv
// Bench joining the glue end and the display end over the link.
// Assumes APB access to the glue registers and a single 10 MHz pclk.
`timescale 1ns/10ps
`default_nettype none
module host_bus_strap_glue_tb_top import hbs_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pslverr, pready;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic err, transfer_ack_n, transfer_ack_oe_n;
	logic [2:0] bus_sel; // Host bus select straps
	logic byte_order, polarity, refresh_busy, panel_power_req;
	logic panel_power_out, big_endian, config_valid;
	hbs_mode_t host_mode;
	int failures, check_count;
	// Expected mode per strap code with bus start low
	hbs_mode_t exp_m [8] = '{HBS_MODE_STRB_A, HBS_MODE_STRB_B, HBS_MODE_RSVD,
		HBS_MODE_DS_A, HBS_MODE_RSVD, HBS_MODE_DS_B, HBS_MODE_RSVD, HBS_MODE_GEN1};

	hbs_link_if link();
	hbs_host i_hbs_host (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .transfer_ack_n(transfer_ack_n),
		.transfer_ack_oe_n(transfer_ack_oe_n), .link(link));
	hbs_device i_hbs_device (.pclk(pclk), .presetn(presetn), .link(link),
		.bus_select_strap_0(bus_sel[0]), .bus_select_strap_1(bus_sel[1]),
		.bus_select_strap_2(bus_sel[2]), .byte_order_strap(byte_order),
		.panel_power_polarity_strap(polarity), .refresh_busy(refresh_busy),
		.panel_power_req(panel_power_req), .panel_power_out(panel_power_out),
		.host_mode(host_mode), .big_endian(big_endian), .config_valid(config_valid));
	hbs_assertions i_hbs_assertions (.pclk(pclk), .presetn(presetn), .cs_n(link.cs_n),
		.wait_n(link.wait_n), .dev_data_oe_n(link.dev_data_oe_n),
		.low_byte_write_n(link.low_byte_write_n),
		.high_byte_write_n(link.high_byte_write_n),
		.low_byte_read_n(link.low_byte_read_n), .high_byte_read_n(link.high_byte_read_n),
		.bus_start_strobe_n(link.bus_start_strobe_n), .transfer_ack_n(transfer_ack_n),
		.transfer_ack_oe_n(transfer_ack_oe_n));

	// *****
	// Shared tasks
	// *****
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// A hang counts as a mismatch and closes the run
	task automatic hang(input string nm);
		failures++;
		$display("mismatch %s expected response seen timeout", nm);
		test_done();
	endtask

	// One APB transfer; entered just after an edge, leaves one idle cycle
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (n == 20) hang("pready");
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Straps stand before and after release, as the device expects
	task automatic rst(input logic [2:0] c, input logic bo, pol);
		int n;
		presetn <= 1'b0;
		bus_sel <= c;
		byte_order <= bo;
		polarity <= pol;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (n = 0; n < 20 && config_valid !== 1'b1; n++) @(posedge pclk);
		if (n == 20) hang("config_valid");
		@(posedge pclk);
	endtask

	// One device cycle; wire levels checked while the select is low
	task automatic cyc(input logic rd, input logic [15:0] a, d, input logic [1:0] s);
		int n;
		apb(1'b1, HBS_ADDR_OFS, {16'h0, a});
		apb(1'b1, HBS_WDATA_OFS, {16'h0, d});
		apb(1'b1, HBS_STRB_OFS, {30'h0, s});
		apb(1'b1, HBS_CMD_OFS, {30'h0, rd, 1'b1});
		for (n = 0; n < 10 && link.cs_n !== 1'b0; n++) @(posedge pclk);
		if (n == 10) hang("cs_n");
		chk("addr", {16'h0, a}, {16'h0, link.addr});
		chk("hi_we", {31'h0, rd | !s[0]}, {31'h0, link.high_byte_write_n});
		chk("lo_we", {31'h0, rd | !s[1]}, {31'h0, link.low_byte_write_n});
		chk("rd_n", {31'h0, !rd}, {31'h0, link.low_byte_read_n});
		chk("bus_start", 0, {31'h0, link.bus_start_strobe_n});
		for (n = 0; n < 30; n++) begin
			apb(1'b0, HBS_STAT_OFS, 32'h0);
			if (q[HBS_STAT_DONE_BIT] === 1'b1) break;
		end
		if (n == 30) hang("done");
		apb(1'b1, HBS_STAT_OFS, 32'h2);
	endtask

	// *****
	// Scenarios
	// *****
	task automatic t_modes();
		for (int c = 0; c < 8; c++) begin
			rst(3'(c), c[0], c[1]);
			chk("mode", {29'h0, exp_m[c]}, {29'h0, host_mode});
			chk("endian", {31'h0, c[0]}, {31'h0, big_endian});
			panel_power_req <= 1'b1;
			repeat (2) @(posedge pclk);
			chk("pwr_on", {31'h0, c[1]}, {31'h0, panel_power_out});
			panel_power_req <= 1'b0;
			bus_sel <= ~3'(c);
			byte_order <= !c[0];
			polarity <= !c[1];
			repeat (4) @(posedge pclk);
			chk("pwr_off", {31'h0, !c[1]}, {31'h0, panel_power_out});
			chk("mode_kept", {29'h0, exp_m[c]}, {29'h0, host_mode});
			chk("endian_kept", {31'h0, c[0]}, {31'h0, big_endian});
		end
		$display("test modes done");
	endtask

	task automatic t_regs();
		rst(3'h7, 1'b0, 1'b1);
		apb(1'b0, HBS_STRB_OFS, 32'h0);
		chk("strb_rst", {30'h0, HBS_STRB_RST}, q);
		apb(1'b0, HBS_RDATA_OFS, 32'h0);
		chk("rdata_rst", {16'h0, HBS_RDATA_RST}, q);
		apb(1'b1, 12'h020, 32'h1);
		chk("unmapped", 1, {31'h0, err});
		chk("ack_oe_idle", 1, {31'h0, transfer_ack_oe_n});
		$display("test regs done");
	endtask

	// Byte strobes, ignored address bit 0 and the last word
	task automatic t_data();
		cyc(1'b0, 16'h0002, 16'h1234, 2'h3);
		cyc(1'b0, 16'h0002, 16'hab00, 2'h1);
		cyc(1'b0, 16'h0003, 16'h00cd, 2'h2);
		cyc(1'b0, 16'h003e, 16'h5a5a, 2'h3);
		cyc(1'b1, 16'h0002, 16'h0000, 2'h0);
		apb(1'b0, HBS_RDATA_OFS, 32'h0);
		chk("rd_bytes", 32'h0000abcd, q);
		cyc(1'b1, 16'h003e, 16'h0000, 2'h0);
		apb(1'b0, HBS_RDATA_OFS, 32'h0);
		chk("rd_last", 32'h00005a5a, q);
		$display("test data done");
	endtask

	// Refresh holds the read; acknowledge must wait for it
	// The select falls after edge 16, so edge 24 is well inside the stall
	task automatic t_stall();
		refresh_busy <= 1'b1;
		fork
			cyc(1'b1, 16'h0002, 16'h0000, 2'h0);
			begin
				repeat (24) @(posedge pclk);
				chk("wait_hold", 0, {31'h0, link.wait_n});
				chk("ack_hold", 1, {31'h0, transfer_ack_n});
				chk("ack_oe_sel", 0, {31'h0, transfer_ack_oe_n});
				refresh_busy <= 1'b0;
			end
		join
		apb(1'b0, HBS_RDATA_OFS, 32'h0);
		chk("rd_stall", 32'h0000abcd, q);
		$display("test stall done");
	endtask

	// Big-endian storage must still return what was written
	task automatic t_endian();
		rst(3'h7, 1'b1, 1'b1);
		chk("big", 1, {31'h0, big_endian});
		cyc(1'b0, 16'h0004, 16'h1234, 2'h3);
		cyc(1'b0, 16'h0004, 16'h0077, 2'h2);
		cyc(1'b1, 16'h0004, 16'h0000, 2'h0);
		apb(1'b0, HBS_RDATA_OFS, 32'h0);
		chk("rd_big", 32'h00001277, q);
		$display("test endian done");
	endtask

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, refresh_busy, panel_power_req} = 5'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		bus_sel = 3'h7;
		{byte_order, polarity} = 2'h1;
		failures = 0;
		check_count = 0;
		@(posedge pclk);
		t_modes();
		t_regs();
		t_data();
		t_stall();
		t_endian();
		test_done();
	end
endmodule
`default_nettype wire
